// >>> design/adsp_serial_pins.v
`timescale 1ns/10ps
`include "adsp_defines.vh"
// Summary of operation
// - End-of-conversion is active low; data valid after fall
// - Modes 00, 01, 10 shift output on falling edge
// - Mode 11 shifts output on rising edge
// - Data output undriven while chip select high
// - Input bit sampled on serial clock falling edge
// - Interface active only while chip select low
// - Load input asynchronous, active low, updates DAC
// - Load held low makes DAC registers transparent
// - Power-up select sets input registers FFFh or 000h
module adsp_serial_pins (
   // Clock, reset, enable
   input  wire                                   clk,
   input  wire                                   rst_n,
   input  wire                                   clk_en,
   // Serial pins
   input  wire                                   sclk,
   input  wire                                   cs_n,
   input  wire                                   din,
   output wire                                   dout,
   output wire                                   dout_oe,
   output wire                                   eoc_n,
   // DAC pins and strap
   input  wire                                   dac_load_n,
   input  wire                                   power_up_select,
   input  wire [1:0]                             clock_mode,
   // Converter side
   input  wire [`ADSP_ADC_W-1:0]                 adc_result,
   input  wire                                   adc_result_valid,
   output wire [`ADSP_DAC_N*`ADSP_DAC_W-1:0]     dac_out,
   output wire [`ADSP_WORD_W-1:0]                rx_word,
   output wire                                   rx_word_valid
);

   // Synchronisers: stage 1 only feeds stage 2
   reg [2:0]                    sclk_sync_ff;
   reg [2:0]                    cs_sync_ff;
   reg [1:0]                    din_sync_ff;
   reg [1:0]                    load_sync_ff;
   reg [1:0]                    pus_sync_ff;

   reg [1:0]                    init_cnt_ff;
   reg [1:0]                    init_st_ff;
   reg [1:0]                    nxt_init_st;
   wire                         init_load;
   reg [`ADSP_WORD_W-1:0]       rx_sr_ff;
   reg [`ADSP_CNT_W-1:0]        bit_cnt_ff;
   reg [`ADSP_WORD_W-1:0]       rx_word_ff;
   reg                          rx_valid_ff;
   reg [`ADSP_WORD_W-1:0]       tx_sr_ff;
   reg [`ADSP_ADC_W-1:0]        result_ff;
   reg                          eoc_n_ff;
   reg [`ADSP_DAC_W-1:0]        in_reg_ff  [0:`ADSP_DAC_N-1];
   reg [`ADSP_DAC_W-1:0]        dac_reg_ff [0:`ADSP_DAC_N-1];

   wire                         sclk_fall;
   wire                         sclk_rise;
   wire                         cs_active;
   wire                         cs_fall;
   wire                         shift_edge;
   wire                         load_active;
   wire [`ADSP_WORD_W-1:0]      nxt_rx_sr;
   wire                         word_done;
   wire [`ADSP_CH_W-1:0]        wr_ch;
   integer                      i;

   // Power-up sequencer states
   localparam [1:0] ST_WAIT = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;

   // Edge finders on the settled synchroniser stages
   function fall_of;
      input [1:0] st;
      begin
         fall_of = st[1] & ~st[0];
      end
   endfunction

   function rise_of;
      input [1:0] st;
      begin
         rise_of = ~st[1] & st[0];
      end
   endfunction

   // Power-up code picked by the strap
   function [`ADSP_DAC_W-1:0] strap_code;
      input sel;
      begin
         strap_code = sel ? `ADSP_DAC_FULL : `ADSP_DAC_ZERO;
      end
   endfunction

   // Edges seen from the settled stages only
   assign sclk_fall   = fall_of(sclk_sync_ff[2:1]);
   assign sclk_rise   = rise_of(sclk_sync_ff[2:1]);
   assign cs_active   = ~cs_sync_ff[1];
   assign cs_fall     = fall_of(cs_sync_ff[2:1]);
   assign init_load   = (init_st_ff == ST_WAIT) &
                        (init_cnt_ff == `ADSP_INIT_WAIT);
   assign shift_edge  = (clock_mode == `ADSP_MODE_RISE) ?
                        sclk_rise :
                        sclk_fall;
   assign load_active = ~load_sync_ff[1];
   assign nxt_rx_sr   = {rx_sr_ff[`ADSP_WORD_W-2:0], din_sync_ff[1]};
   assign word_done   = cs_active & sclk_fall & (bit_cnt_ff == `ADSP_CNT_LAST);
   assign wr_ch       = nxt_rx_sr[`ADSP_CH_HI:`ADSP_CH_LO];

   assign dout          = tx_sr_ff[`ADSP_WORD_W-1];
   assign dout_oe       = cs_active;
   assign eoc_n         = eoc_n_ff;
   assign rx_word       = rx_word_ff;
   assign rx_word_valid = rx_valid_ff;

   genvar g;
   generate
      for (g = 0; g < `ADSP_DAC_N; g = g + 1) begin : g_dac
         assign dac_out[g*`ADSP_DAC_W +: `ADSP_DAC_W] = dac_reg_ff[g];
      end
   endgenerate

   // Pin synchronisers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_ff <= 3'h0;
         cs_sync_ff   <= 3'h7;
         din_sync_ff  <= 2'h0;
         load_sync_ff <= 2'h3;
         pus_sync_ff  <= 2'h0;
      end else if (clk_en) begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
         cs_sync_ff   <= {cs_sync_ff[1:0], cs_n};
         din_sync_ff  <= {din_sync_ff[0], din};
         load_sync_ff <= {load_sync_ff[0], dac_load_n};
         pus_sync_ff  <= {pus_sync_ff[0], power_up_select};
      end
   end

   // Receive path
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sr_ff    <= `ADSP_WORD_RST;
         bit_cnt_ff  <= `ADSP_CNT_RST;
         rx_word_ff  <= `ADSP_WORD_RST;
         rx_valid_ff <= 1'b0;
      end else if (clk_en) begin
         rx_valid_ff <= 1'b0;
         if (!cs_active) begin
            // Partial bits never leak into the next frame
            rx_sr_ff   <= `ADSP_WORD_RST;
            bit_cnt_ff <= `ADSP_CNT_RST;
         end else if (sclk_fall) begin
            rx_sr_ff   <= nxt_rx_sr;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (word_done) begin
               rx_word_ff  <= nxt_rx_sr;
               rx_valid_ff <= 1'b1;
            end
         end
      end
   end

   // Transmit path and end-of-conversion flag
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sr_ff  <= `ADSP_WORD_RST;
         result_ff <= {`ADSP_ADC_W{1'b0}};
         eoc_n_ff  <= 1'b1;
      end else if (clk_en) begin
         if (cs_fall) begin
            tx_sr_ff <= {{(`ADSP_WORD_W-`ADSP_ADC_W){1'b0}}, result_ff};
         end else if (cs_active && shift_edge) begin
            tx_sr_ff <= {tx_sr_ff[`ADSP_WORD_W-2:0], 1'b0};
         end
         // A new result wins over the read that clears the flag
         if (adc_result_valid) begin
            result_ff <= adc_result;
            eoc_n_ff  <= 1'b0;
         end else if (cs_fall) begin
            eoc_n_ff  <= 1'b1;
         end
      end
   end

   // Power-up sequencer: strap is read once its synchroniser has settled
   always @* begin
      nxt_init_st = init_st_ff;
      case (init_st_ff)
         ST_WAIT: begin
            if (init_load) begin
               nxt_init_st = ST_RUN;
            end
         end
         ST_RUN: begin
            nxt_init_st = ST_RUN;
         end
         default: begin
            nxt_init_st = ST_WAIT;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_st_ff  <= ST_WAIT;
         init_cnt_ff <= 2'h0;
      end else if (clk_en) begin
         init_st_ff <= nxt_init_st;
         if (init_st_ff == ST_WAIT) begin
            init_cnt_ff <= init_cnt_ff + 2'h1;
         end
      end
   end

   // DAC input and output registers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `ADSP_DAC_N; i = i + 1) begin
            in_reg_ff[i]  <= `ADSP_DAC_ZERO;
            dac_reg_ff[i] <= `ADSP_DAC_ZERO;
         end
      end else if (clk_en) begin
         if (init_load) begin
            for (i = 0; i < `ADSP_DAC_N; i = i + 1) begin
               in_reg_ff[i] <= strap_code(pus_sync_ff[1]);
            end
         end else if ((init_st_ff == ST_RUN) && word_done &&
                      nxt_rx_sr[`ADSP_WR_BIT]) begin
            // Writes before the strap load are dropped
            in_reg_ff[wr_ch] <= nxt_rx_sr[`ADSP_DATA_HI:0];
         end
         if (load_active) begin
            for (i = 0; i < `ADSP_DAC_N; i = i + 1) begin
               dac_reg_ff[i] <= in_reg_ff[i];
            end
         end
      end
   end

endmodule // adsp_serial_pins

// >>> design/adsp_defines.vh
`ifndef ADSP_DEFINES_VH
`define ADSP_DEFINES_VH

// Serial word and field layout
`define ADSP_WORD_W      16
`define ADSP_CNT_W       4
`define ADSP_CNT_LAST    4'hf
`define ADSP_WR_BIT      15
`define ADSP_CH_HI       14
`define ADSP_CH_LO       12
`define ADSP_DATA_HI     11

// Converter widths
`define ADSP_ADC_W       10
`define ADSP_DAC_W       12
`define ADSP_DAC_N       8
`define ADSP_CH_W        3

// Power-up codes of the DAC input registers
`define ADSP_DAC_FULL    12'hfff
`define ADSP_DAC_ZERO    12'h000

// Clock mode that shifts on the rising serial clock edge
`define ADSP_MODE_RISE   2'h3

// Clocks to wait for the strap synchroniser to settle
`define ADSP_INIT_WAIT   2'h2

// Reset values
`define ADSP_WORD_RST    16'h0000
`define ADSP_CNT_RST     4'h0

`endif

// >>> bench/adsp_serial_pins_asserts.sv
`timescale 1ns/10ps
`include "adsp_defines.vh"
module adsp_chk (
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   input wire        clk_en,
   // Pins
   input wire        sclk,
   input wire        cs_n,
   input wire        dout,
   input wire        dout_oe,
   input wire        eoc_n,
   input wire        dac_load_n,
   input wire [1:0]  clock_mode,
   // Converter side
   input wire        adc_result_valid,
   input wire [95:0] dac_out,
   input wire [15:0] rx_word,
   input wire        rx_word_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || !clk_en);
   oe_on_a: assert property (!cs_n [*3] |-> dout_oe)
      else $error("dout not enabled");
   oe_off_a: assert property (cs_n [*3] |-> !dout_oe)
      else $error("dout driven");
   eoc_set_a: assert property (adc_result_valid |=> !eoc_n)
      else $error("eoc late");
   eoc_hold_a: assert property (cs_n [*4] ##0 !eoc_n |=> !eoc_n)
      else $error("eoc lost");
   rx_quiet_a: assert property (cs_n [*8] |-> !rx_word_valid)
      else $error("word outside frame");
   rx_pair_a: assert property ($changed(rx_word) |-> rx_word_valid)
      else $error("word without strobe");
   fall_shift_a: assert property (clock_mode != `ADSP_MODE_RISE
      && dout_oe && $past(dout_oe, 4) && $changed(dout)
      |-> $past(sclk, 4) && !$past(sclk, 3)) else $error("bad fall shift");
   rise_shift_a: assert property (clock_mode == `ADSP_MODE_RISE
      && dout_oe && $past(dout_oe, 4) && $changed(dout)
      |-> !$past(sclk, 4) && $past(sclk, 3)) else $error("bad rise shift");
   dac_hold_a: assert property (dac_load_n [*4] |-> $stable(dac_out))
      else $error("dac moved");
   cover property (rx_word_valid);
   cover property ($fell(eoc_n));
   cover property (clock_mode == `ADSP_MODE_RISE && $changed(dout));
endmodule // adsp_chk
bind adsp_serial_pins adsp_chk i_chk (.clk(clk), .rst_n(rst_n),
   .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n), .dout(dout),
   .dout_oe(dout_oe), .eoc_n(eoc_n), .dac_load_n(dac_load_n),
   .clock_mode(clock_mode), .adc_result_valid(adc_result_valid),
   .dac_out(dac_out), .rx_word(rx_word), .rx_word_valid(rx_word_valid));

// >>> bench/adsp_host.sv
`timescale 1ns/10ps
module adsp_host (
   // Pins
   input  wire clk,
   input  wire dout,
   output reg  sclk,
   output reg  cs_n,
   output reg  din
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // Read before each rise suits every clock mode
   task xfer(input [15:0] w, input integer n, output [15:0] r);
      integer i;
      begin
         @(negedge clk) cs_n = 1'b0;
         for (i = 0; i < n; i = i + 1) begin
            repeat (4) @(negedge clk);
            r = {r[14:0], dout};
            din = w[15-i];
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
         end
         repeat (4) @(negedge clk);
         cs_n = 1'b1;
         din = ~din; // Last bit inverted once released
         repeat (10) @(negedge clk);
      end
   endtask
endmodule // adsp_host

// >>> bench/adsp_serial_pins_tb_top.sv
`timescale 1ns/10ps
module adsp_serial_pins_tb_top;
   reg         clk = 0, rst_n = 0, dac_load_n = 0, power_up_select = 1;
   reg         adc_result_valid = 0;
   reg  [1:0]  clock_mode = 0;
   reg  [9:0]  adc_result = 0;
   reg  [15:0] r, w;
   reg  [11:0] old_val;
   wire        sclk, cs_n, din, dout_bit, dout_oe, eoc_n, rx_word_valid;
   wire [95:0] dac_out;
   wire [15:0] rx_word;
   wire        dout_w = dout_oe ? dout_bit : 1'bz;
   integer     fails = 0, samples_checked = 0, seed = 63, k;
   always #25 clk = ~clk;
   adsp_host i_host (.clk(clk), .dout(dout_w), .sclk(sclk), .cs_n(cs_n),
      .din(din));
   adsp_serial_pins i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
      .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_bit),
      .dout_oe(dout_oe), .eoc_n(eoc_n), .dac_load_n(dac_load_n),
      .power_up_select(power_up_select), .clock_mode(clock_mode),
      .adc_result(adc_result), .adc_result_valid(adc_result_valid),
      .dac_out(dac_out), .rx_word(rx_word), .rx_word_valid(rx_word_valid));
   task chk(input [95:0] s, input [95:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   function [15:0] tx_exp(input [9:0] res);
      tx_exp = {6'h0, res};
   endfunction
   function [11:0] dac_exp(input held, input [11:0] old, input [11:0] wr);
      dac_exp = held ? old : wr;
   endfunction
   task do_reset(input v);
      begin
         @(negedge clk) rst_n = 0;
         power_up_select = v;
         repeat (3) @(negedge clk);
         rst_n = 1;
         repeat (10) @(negedge clk);
      end
   endtask
   task finish_test;
      begin
         $display("fails=%0d samples_checked=%0d", fails, samples_checked);
         if (fails == 0 && samples_checked > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      do_reset(1);
      chk(dac_out, {8{12'hfff}});
      do_reset(0);
      chk(dac_out, 0);
      for (k = 0; k < 8; k = k + 1) begin
         clock_mode = k[1:0];
         adc_result = $random(seed);
         w = $random(seed) & 16'h7fff;
         adc_result_valid = 1;
         @(negedge clk) adc_result_valid = 0;
         @(negedge clk) chk(eoc_n, 0);
         chk(dout_oe, 0);
         i_host.xfer(w, 16, r);
         chk(r, tx_exp(adc_result));
         chk(rx_word, w);
         chk(eoc_n, 1);
         dac_load_n = k[0];
         w = $random(seed) | 16'h8000;
         old_val = dac_out[12*w[14:12] +: 12];
         i_host.xfer($random(seed), 5, r);
         i_host.xfer(w, 16, r);
         chk(rx_word, w);
         chk(dac_out[12*w[14:12] +: 12], dac_exp(k[0], old_val, w[11:0]));
         dac_load_n = 0;
         repeat (5) @(negedge clk);
         chk(dac_out[12*w[14:12] +: 12], w[11:0]);
      end
      finish_test;
   end
   initial begin
      #800000;
      fails = fails + 1;
      finish_test;
   end
endmodule // adsp_serial_pins_tb_top
